// ### logic/aout_buffer.sv
// analog output sample buffer: host port, correction, FIFO, playout
// assumes a 32-bit register port on clk_i; clock and trigger pins async
// Functional notes
// - marker stored beside its sample in FIFO
// - span select 10/5/2.5 V, 10 V after reset
// - samples corrected before entering 256K FIFO
// - capacity per channel is depth over actives
// - bits 15..0 sample, 16 marker, rest ignored
// - sample port write-only, reads return zero
// - flush bit empties the FIFO
// - write to full FIFO dropped, overrun flagged
// - write while closed flags closed-write error
// - error flags sticky until written low
// - empty and full flags track fill count
// - fill count in low 19 bits, rest zero
// - threshold default 3fffe, flag when count exceeds
// - open mode discards each played sample
// - circular mode requeues samples, refuses writes
// - several marked frames may be stored together
// - circular continuous mode replays frame endlessly
// - each trigger plays one frame to marker
// - successive triggers play successive stored frames
// - circular control resets low
// - flush bit clears itself when done
`timescale 1ns/100ps
`default_nettype none
module aout_buffer #(
	parameter int AW = 18
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire logic out_clk_pin_i,
	input wire logic trig_pin_i,
	output logic [15:0] dac_data_o,
	output logic dac_eof_o,
	output logic dac_valid_o,
	output aout_pkg::span_e span_o
);
	// ==========================================================
	// declarations
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH = CW'(1 << AW);
	typedef enum logic {B_IDLE, B_RUN} burst_e;

	logic [1:0] chmask_reg; // active channel mask
	logic clk_en_reg; // output clocking enable
	logic circ_reg; // circular (closed) buffer select
	logic flush_reg; // self-clearing flush request
	logic burst_en_reg; // triggered burst mode
	logic sw_trig_reg; // self-clearing software trigger
	logic ovr_reg; // write-overrun sticky flag
	logic frm_reg; // closed-write sticky flag
	logic thr_flag_reg; // count above threshold
	logic empty_reg;
	logic full_reg;
	logic [aout_pkg::THR_W-1:0] thresh_reg;
	logic [15:0] gain_reg;
	logic [15:0] offset_reg;
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic [CW-1:0] cap_reg; // samples per active channel
	logic pop_d_reg; // read data valid this cycle
	logic circ_d_reg; // mode at the time of that read
	burst_e state_reg;
	// pin synchronisers: meta -> s2 -> s3, filtered level
	logic [1:0] meta_reg;
	logic [1:0] s2_reg;
	logic [1:0] s3_reg;
	logic [1:0] lvl_reg;
	logic [1:0] lvl_prev_reg;

	logic host_wr; // write to the sample port
	logic hit_ops;
	aout_pkg::sample_s host_sample;
	logic corr_valid;
	aout_pkg::sample_s corr_sample;
	aout_pkg::sample_s rd_sample;
	logic [16:0] rd_raw;
	logic tick; // sample clock event
	logic trig_edge; // hardware trigger event
	logic trig_go;
	logic pop;
	logic requeue;
	logic push;
	logic drop_full;
	logic drop_closed;
	logic ram_we;
	aout_pkg::sample_s ram_wdata;

	// ==========================================================
	// decode and host sample capture
	assign host_wr = reg_wr_i && reg_addr_i == aout_pkg::OFS_SAMPLE;
	assign hit_ops = reg_wr_i && reg_addr_i == aout_pkg::OFS_OPS;
	// upper bits 31..17 simply never reach the buffer
	assign host_sample.value = reg_wdata_i[15:0];
	assign host_sample.eof = reg_wdata_i[aout_pkg::EOF_BIT];

	// correction ahead of the FIFO; closed buffer never sees writes
	aout_corrector u_corr (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(host_wr && !circ_reg),
		.in_sample_i(host_sample),
		.gain_i(gain_reg),
		.offset_i(offset_reg),
		.out_valid_o(corr_valid),
		.out_sample_o(corr_sample)
	);

	// ==========================================================
	// pin synchronisers; a change counts once s2 and s3 agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= 2'h3;
			s2_reg <= 2'h3;
			s3_reg <= 2'h3;
			lvl_reg <= 2'h3;
			lvl_prev_reg <= 2'h3;
		end else begin
			meta_reg <= {trig_pin_i, out_clk_pin_i};
			s2_reg <= meta_reg;
			s3_reg <= s2_reg;
			lvl_reg <= (~(s2_reg ^ s3_reg) & s3_reg)
				| ((s2_reg ^ s3_reg) & lvl_reg);
			lvl_prev_reg <= lvl_reg;
		end
	end
	// sample clock acts on its falling edge, trigger on rising
	assign tick = lvl_prev_reg[0] && !lvl_reg[0];
	assign trig_edge = !lvl_prev_reg[1] && lvl_reg[1];

	// ==========================================================
	// playout and FIFO movement
	assign trig_go = burst_en_reg && state_reg == B_IDLE
		&& (sw_trig_reg || trig_edge);
	// continuous mode plays every tick; burst mode only inside a burst
	assign pop = tick && clk_en_reg && !empty_reg && !flush_reg
		&& (!burst_en_reg || state_reg == B_RUN);
	// circular mode writes each played sample back behind the tail
	assign requeue = pop_d_reg && circ_d_reg && !flush_reg;
	assign push = corr_valid && !full_reg && !requeue && !flush_reg;
	assign drop_full = corr_valid && full_reg && !flush_reg;
	assign drop_closed = (host_wr && circ_reg)
		|| (corr_valid && requeue);
	assign ram_we = push || requeue;
	assign ram_wdata = requeue ? rd_sample : corr_sample;
	assign rd_sample = aout_pkg::sample_s'(rd_raw);

	aout_sample_ram #(
		.AW(AW),
		.W(17)
	) u_ram (
		.clk_i(clk_i),
		.we_i(ram_we),
		.waddr_i(wr_ptr_reg),
		.wdata_i(ram_wdata),
		.raddr_i(rd_ptr_reg),
		.rdata_o(rd_raw)
	);

	// fill count: open pops leave, circular pops come back
	always_comb begin
		count_next = count_reg;
		if (flush_reg) begin
			count_next = '0;
		end else begin
			if (push) begin
				count_next = count_next + CW'(1);
			end
			if (pop && !circ_reg) begin
				count_next = count_next - CW'(1);
			end
		end
	end

	// pointers and count cleared by a flush; empty flag set, full flag cleared
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			empty_reg <= 1'b1;
			full_reg <= 1'b0;
			pop_d_reg <= 1'b0;
			circ_d_reg <= 1'b0;
		end else begin
			if (flush_reg) begin
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
			end else begin
				if (ram_we) begin
					wr_ptr_reg <= wr_ptr_reg + AW'(1);
				end
				if (pop) begin
					rd_ptr_reg <= rd_ptr_reg + AW'(1);
				end
			end
			count_reg <= count_next;
			empty_reg <= count_next == '0;
			full_reg <= count_next == DEPTH;
			pop_d_reg <= pop;
			circ_d_reg <= circ_reg;
		end
	end

	// converter outputs take the sample one cycle after the pop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dac_data_o <= '0;
			dac_eof_o <= 1'b0;
			dac_valid_o <= 1'b0;
		end else begin
			dac_valid_o <= pop_d_reg;
			if (pop_d_reg) begin
				dac_data_o <= rd_sample.value;
				dac_eof_o <= rd_sample.eof;
			end
		end
	end

	// burst sequencer: one frame per trigger, stop at the marker
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= B_IDLE;
		end else begin
			unique case (state_reg)
				B_IDLE: begin
					if (trig_go) begin
						state_reg <= B_RUN;
					end
				end
				B_RUN: begin
					// marker ends the burst; an empty open buffer does too
					if (!burst_en_reg || flush_reg
						|| (pop_d_reg && rd_sample.eof)
						|| (empty_reg && !circ_reg)) begin
						state_reg <= B_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// control register fields
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chmask_reg <= aout_pkg::CHMASK_RST;
			clk_en_reg <= 1'b0;
			circ_reg <= 1'b0;
			burst_en_reg <= 1'b0;
		end else if (hit_ops) begin
			chmask_reg <= reg_wdata_i[aout_pkg::OPS_CH1:aout_pkg::OPS_CH0];
			clk_en_reg <= reg_wdata_i[aout_pkg::OPS_CLK_EN];
			circ_reg <= reg_wdata_i[aout_pkg::OPS_CIRC];
			burst_en_reg <= reg_wdata_i[aout_pkg::OPS_BURST];
		end
	end

	// self-clearing flush and software trigger
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flush_reg <= 1'b0;
			sw_trig_reg <= 1'b0;
		end else begin
			// flush takes one cycle, then the bit drops
			if (hit_ops && reg_wdata_i[aout_pkg::OPS_CLEAR]) begin
				flush_reg <= 1'b1;
			end else begin
				flush_reg <= 1'b0;
			end
			// trigger clears once a burst starts or if bursts are off
			if (hit_ops && reg_wdata_i[aout_pkg::OPS_SWTRIG]) begin
				sw_trig_reg <= 1'b1;
			end else if (trig_go || !burst_en_reg) begin
				sw_trig_reg <= 1'b0;
			end
		end
	end

	// sticky error flags: a new error wins over a clearing write
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovr_reg <= 1'b0;
			frm_reg <= 1'b0;
		end else begin
			if (drop_full) begin
				ovr_reg <= 1'b1;
			end else if (hit_ops && !reg_wdata_i[aout_pkg::OPS_OVR]) begin
				ovr_reg <= 1'b0;
			end
			if (drop_closed) begin
				frm_reg <= 1'b1;
			end else if (hit_ops && !reg_wdata_i[aout_pkg::OPS_FRM]) begin
				frm_reg <= 1'b0;
			end
		end
	end

	// threshold, correction, span and per-channel capacity
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thresh_reg <= aout_pkg::THRESH_RST;
			gain_reg <= aout_pkg::GAIN_RST;
			offset_reg <= aout_pkg::OFFSET_RST;
			span_o <= aout_pkg::SPAN_10V;
			thr_flag_reg <= 1'b0;
			cap_reg <= DEPTH;
		end else begin
			if (reg_wr_i && reg_addr_i == aout_pkg::OFS_THRESH) begin
				thresh_reg <= reg_wdata_i[aout_pkg::THR_W-1:0];
			end
			if (reg_wr_i && reg_addr_i == aout_pkg::OFS_CORR) begin
				gain_reg <= reg_wdata_i[15:0];
				offset_reg <= reg_wdata_i[31:16];
			end
			// the unused fourth code is ignored, span keeps its value
			if (reg_wr_i && reg_addr_i == aout_pkg::OFS_CONFIG
				&& reg_wdata_i[1:0] != 2'h3) begin
				span_o <= aout_pkg::span_e'(reg_wdata_i[1:0]);
			end
			thr_flag_reg <= 32'(count_reg) > 32'(thresh_reg);
			// two active channels halve the share of each
			cap_reg <= (&chmask_reg) ? (DEPTH >> 1) : DEPTH;
		end
	end

	// ==========================================================
	// read data; unmapped addresses and the sample port read zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= '0;
			unique case (reg_addr_i)
				aout_pkg::OFS_OPS: begin
					reg_rdata_o[aout_pkg::OPS_CH1:aout_pkg::OPS_CH0] <= chmask_reg;
					reg_rdata_o[aout_pkg::OPS_CLK_EN] <= clk_en_reg;
					reg_rdata_o[aout_pkg::OPS_CIRC] <= circ_reg;
					reg_rdata_o[aout_pkg::OPS_CLEAR] <= flush_reg;
					reg_rdata_o[aout_pkg::OPS_EMPTY] <= empty_reg;
					reg_rdata_o[aout_pkg::OPS_THR] <= thr_flag_reg;
					reg_rdata_o[aout_pkg::OPS_FULL] <= full_reg;
					reg_rdata_o[aout_pkg::OPS_OVR] <= ovr_reg;
					reg_rdata_o[aout_pkg::OPS_FRM] <= frm_reg;
					reg_rdata_o[aout_pkg::OPS_BRDY] <= burst_en_reg
						&& state_reg == B_IDLE && !empty_reg;
					reg_rdata_o[aout_pkg::OPS_BURST] <= burst_en_reg;
					reg_rdata_o[aout_pkg::OPS_SWTRIG] <= sw_trig_reg;
				end
				aout_pkg::OFS_SIZE: begin
					reg_rdata_o <= 32'(count_reg);
				end
				aout_pkg::OFS_THRESH: begin
					reg_rdata_o[aout_pkg::THR_W-1:0] <= thresh_reg;
					reg_rdata_o[aout_pkg::THR_FLAG_BIT] <= thr_flag_reg;
				end
				aout_pkg::OFS_CORR: begin
					reg_rdata_o <= {offset_reg, gain_reg};
				end
				aout_pkg::OFS_CONFIG: begin
					reg_rdata_o[1:0] <= span_o;
				end
				aout_pkg::OFS_CAP: begin
					reg_rdata_o <= 32'(cap_reg);
				end
				default: begin
					reg_rdata_o <= '0;
				end
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_flush_req;
		hit_ops && reg_wdata_i[aout_pkg::OPS_CLEAR];
	endsequence
	// a second flush taken right behind the first may keep the bit up
	sequence s_flush_done;
		flush_reg ##1 (count_reg == '0 && (!flush_reg
			|| $past(hit_ops && reg_wdata_i[aout_pkg::OPS_CLEAR])));
	endsequence

	property p_flush;
		s_flush_req |=> s_flush_done;
	endproperty
	a_flush: assert property (p_flush) else $error("flush failed");

	property p_overrun;
		corr_valid && full_reg && !flush_reg |=> ovr_reg;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun lost");

	property p_full_hold;
		// a dropped word never grows the count; only an open pop shrinks it
		drop_full |=> count_reg == DEPTH - CW'($past(pop && !circ_reg));
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full grew");

	property p_closed;
		host_wr && circ_reg |=> frm_reg;
	endproperty
	a_closed: assert property (p_closed) else $error("closed lost");

	property p_sticky;
		ovr_reg && !hit_ops |=> ovr_reg;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");

	property p_flags;
		##1 (empty_reg == (count_reg == '0))
			&& (full_reg == (count_reg == DEPTH));
	endproperty
	a_flags: assert property (p_flags) else $error("flag mismatch");

	property p_thresh;
		##1 thr_flag_reg == ($past(32'(count_reg)) > $past(32'(thresh_reg)));
	endproperty
	a_thresh: assert property (p_thresh) else $error("thr flag");

	property p_circ_keep;
		pop && circ_reg && !push && !flush_reg |=> $stable(count_reg);
	endproperty
	a_circ_keep: assert property (p_circ_keep) else $error("circ lost");

	property p_open_drain;
		pop && !circ_reg && !push |=> count_reg == $past(count_reg) - CW'(1);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("no drain");

	property p_burst_stop;
		state_reg == B_RUN && pop_d_reg && rd_sample.eof
			|=> state_reg == B_IDLE ##1 !dac_valid_o [*2];
	endproperty
	a_burst_stop: assert property (p_burst_stop) else $error("no stop");

	property p_port_read;
		reg_rd_i && reg_addr_i == aout_pkg::OFS_SAMPLE |=> reg_rdata_o == '0;
	endproperty
	a_port_read: assert property (p_port_read) else $error("port read");
endmodule : aout_buffer
`default_nettype wire

// ### logic/aout_pkg.sv
// constants, field layouts and carrier types for the output sample buffer
// assumes a 32-bit register port with byte offsets and one master clock
package aout_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_SAMPLE = 8'h40;
	localparam logic [7:0] OFS_OPS = 8'h44;
	localparam logic [7:0] OFS_SIZE = 8'h48;
	localparam logic [7:0] OFS_THRESH = 8'h50;
	localparam logic [7:0] OFS_CORR = 8'h54;
	localparam logic [7:0] OFS_CONFIG = 8'h58;
	localparam logic [7:0] OFS_CAP = 8'h5c;
	// ==========================================================
	// operations register bit positions
	localparam int OPS_CH0 = 0;
	localparam int OPS_CH1 = 1;
	localparam int OPS_CLK_EN = 5;
	localparam int OPS_CIRC = 8;
	localparam int OPS_CLEAR = 11;
	localparam int OPS_EMPTY = 12;
	localparam int OPS_THR = 13;
	localparam int OPS_FULL = 15;
	localparam int OPS_OVR = 16;
	localparam int OPS_FRM = 17;
	localparam int OPS_BRDY = 18;
	localparam int OPS_BURST = 19;
	localparam int OPS_SWTRIG = 20;
	// ==========================================================
	// sample port and threshold fields
	localparam int EOF_BIT = 16;
	localparam int THR_W = 19;
	localparam int THR_FLAG_BIT = 19;
	// ==========================================================
	// reset values
	localparam logic [THR_W-1:0] THRESH_RST = 19'h3fffe;
	localparam logic [15:0] GAIN_RST = 16'h8000;
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [1:0] CHMASK_RST = 2'h3;
	// ==========================================================
	// output span codes
	typedef enum logic [1:0] {SPAN_10V, SPAN_5V, SPAN_2V5} span_e;
	// one buffered sample with its end-of-frame marker
	typedef struct packed {
		logic eof;
		logic [15:0] value;
	} sample_s;
endpackage : aout_pkg

// ### logic/aout_sample_ram.sv
// simple dual-port sample memory, registered read data
// assumes one clock; writes and reads may hit any address each cycle
`timescale 1ns/100ps
`default_nettype none
module aout_sample_ram #(
	parameter int AW = 18,
	parameter int W = 17
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [W-1:0] rdata_o
);
	// ==========================================================
	// storage, no reset so it maps onto block memory
	logic [W-1:0] mem [0:(1<<AW)-1];

	// write port
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// read port, always reads; caller knows when data is wanted
	always_ff @(posedge clk_i) begin
		rdata_o <= mem[raddr_i];
	end
endmodule : aout_sample_ram
`default_nettype wire

// ### logic/aout_corrector.sv
// offset and gain correction stage, one cycle of latency
// assumes gain 16'h8000 means unity and offset is two's complement
`timescale 1ns/100ps
`default_nettype none
module aout_corrector (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	input wire aout_pkg::sample_s in_sample_i,
	input wire logic [15:0] gain_i,
	input wire logic [15:0] offset_i,
	output logic out_valid_o,
	output aout_pkg::sample_s out_sample_o
);
	// ==========================================================
	// arithmetic, saturating so a large gain cannot wrap the code
	logic signed [32:0] prod;
	logic signed [17:0] scaled;
	logic signed [18:0] sum;
	logic [15:0] sat;

	always_comb begin
		prod = $signed(in_sample_i.value) * $signed({1'b0, gain_i});
		scaled = prod[32:15];
		sum = 19'(scaled) + 19'($signed(offset_i));
		if (sum > 19'sd32767) begin
			sat = 16'h7fff;
		end else if (sum < -19'sd32768) begin
			sat = 16'h8000;
		end else begin
			sat = sum[15:0];
		end
	end

	// ==========================================================
	// output stage; the marker rides along untouched
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_valid_o <= 1'b0;
			out_sample_o <= '0;
		end else begin
			out_valid_o <= in_valid_i;
			out_sample_o.value <= sat;
			out_sample_o.eof <= in_sample_i.eof;
		end
	end
endmodule : aout_corrector
`default_nettype wire

// ### tb/aout_far_end.sv
// far-end model: sample clock and trigger pins, converter-side capture
// assumes pins idle high and that the bench calls its pin tasks in turn
`timescale 1ns/100ps
`default_nettype none
module aout_far_end (
	input wire logic clk_i,
	input wire logic [15:0] dac_data_i,
	input wire logic dac_eof_i,
	input wire logic dac_valid_i,
	output logic out_clk_o,
	output logic trig_o
);
	// ==========================================================
	// captured samples, marker in the top bit
	logic [16:0] got_q [$];

	// pins start idle high, as the synchronisers expect
	initial begin
		out_clk_o = 1'b1;
		trig_o = 1'b1;
	end

	// one sample clock: three cycles high then three low, well over sync needs
	task automatic tick();
		repeat (3) @(posedge clk_i);
		out_clk_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		out_clk_o <= 1'b1;
	endtask : tick

	// one hardware trigger: the rising edge back to idle is the event
	task automatic trig();
		repeat (3) @(posedge clk_i);
		trig_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		trig_o <= 1'b1;
	endtask : trig

	// the valid pulse stands one cycle, so capture on every edge
	always @(posedge clk_i) begin
		if (dac_valid_i === 1'b1)
			got_q.push_back({dac_eof_i, dac_data_i});
	end
endmodule : aout_far_end
`default_nettype wire

// ### tb/aout_buffer_test.sv
// bench for the output sample buffer: register tasks, playout checks
// assumes AW=4 (depth 16); unity correction until the last scenario
`timescale 1ns/100ps
`default_nettype none
module aout_buffer_test;
	// ==========================================================
	// signals and counters
	localparam int DEPTH = 16; // fifo depth for AW=4
	logic clk_i, rst_n_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic out_clk, trig;
	logic [15:0] dac_data;
	logic dac_eof, dac_valid;
	aout_pkg::span_e span;
	int failures = 0;
	int total_checks = 0;

	aout_buffer #(.AW(4)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.out_clk_pin_i(out_clk), .trig_pin_i(trig), .dac_data_o(dac_data),
		.dac_eof_o(dac_eof), .dac_valid_o(dac_valid), .span_o(span));
	aout_far_end far (.clk_i(clk_i), .dac_data_i(dac_data),
		.dac_eof_i(dac_eof), .dac_valid_i(dac_valid), .out_clk_o(out_clk),
		.trig_o(trig));

	// ==========================================================
	// clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		end_sim();
	end

	// ==========================================================
	// access tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// waits first: a sample write lands two edges after it is taken
	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		repeat (3) @(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		cmp(reg_rdata_o & m, exp);
	endtask : rchk
	// converter-side results: count first, then one sample
	task automatic nchk(input int n);
		repeat (10) @(posedge clk_i); // tick sync plus pop, read, output
		cmp(32'(far.got_q.size()), 32'(n));
	endtask : nchk
	task automatic dchk(input int i, input logic [16:0] exp);
		cmp({15'h0, far.got_q[i]}, {15'h0, exp});
	endtask : dchk
	task automatic play(input int k);
		repeat (k) far.tick();
	endtask : play
	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// ==========================================================
	// main sequence
	initial begin
		rst_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// reset state of ops, count, threshold, port and span
		rchk(aout_pkg::OFS_OPS, 32'h3b923, 32'h1003);
		rchk(aout_pkg::OFS_SIZE, 32'hffffffff, 32'h0);
		rchk(aout_pkg::OFS_THRESH, 32'hffffffff, 32'h3fffe);
		rchk(aout_pkg::OFS_SAMPLE, 32'hffffffff, 32'h0);
		cmp({30'h0, span}, 32'h0);
		wr(aout_pkg::OFS_CONFIG, 32'h1);
		wr(aout_pkg::OFS_CONFIG, 32'h3); // unknown span code is ignored
		@(negedge clk_i);
		cmp({30'h0, span}, 32'h1);
		// host recalibrates after the span change: unity gain, no offset
		wr(aout_pkg::OFS_CORR, 32'h00008000);
		rchk(aout_pkg::OFS_CORR, 32'hffffffff, 32'h8000);
		// both channels active share the depth
		rchk(aout_pkg::OFS_CAP, 32'hffffffff, 32'(DEPTH / 2));
		// fill to full, then one more write overruns
		wr(aout_pkg::OFS_THRESH, 32'h3);
		rchk(aout_pkg::OFS_THRESH, 32'h7ffff, 32'h3);
		for (int i = 0; i < DEPTH; i++)
			wr(aout_pkg::OFS_SAMPLE, 32'(i + 1));
		rchk(aout_pkg::OFS_SIZE, 32'hffffffff, 32'(DEPTH));
		rchk(aout_pkg::OFS_OPS, 32'h1b000, 32'ha000);
		rchk(aout_pkg::OFS_THRESH, 32'hffffffff, 32'h80003);
		wr(aout_pkg::OFS_SAMPLE, 32'h7);
		rchk(aout_pkg::OFS_OPS, 32'h10000, 32'h10000);
		rchk(aout_pkg::OFS_SIZE, 32'hffffffff, 32'(DEPTH));
		rchk(aout_pkg::OFS_OPS, 32'h10000, 32'h10000);
		wr(aout_pkg::OFS_OPS, 32'h3);
		rchk(aout_pkg::OFS_OPS, 32'h10000, 32'h0);
		// flush empties and the flush bit clears itself
		wr(aout_pkg::OFS_OPS, 32'h803);
		rchk(aout_pkg::OFS_OPS, 32'h1800, 32'h1000);
		rchk(aout_pkg::OFS_SIZE, 32'hffffffff, 32'h0);
		// open mode: a marked frame plays once and drains
		wr(aout_pkg::OFS_SAMPLE, 32'h00000100);
		wr(aout_pkg::OFS_SAMPLE, 32'hfffe0200);
		wr(aout_pkg::OFS_SAMPLE, 32'h00010300);
		wr(aout_pkg::OFS_OPS, 32'h23);
		play(3);
		nchk(3);
		dchk(0, 17'h00100);
		dchk(1, 17'h00200);
		dchk(2, 17'h10300);
		rchk(aout_pkg::OFS_SIZE, 32'hffffffff, 32'h0);
		// circular: clocking off for the load, then closed to writes
		wr(aout_pkg::OFS_OPS, 32'h3);
		wr(aout_pkg::OFS_SAMPLE, 32'h00000400);
		wr(aout_pkg::OFS_SAMPLE, 32'h00010500);
		wr(aout_pkg::OFS_OPS, 32'h103);
		wr(aout_pkg::OFS_SAMPLE, 32'h00000600);
		rchk(aout_pkg::OFS_OPS, 32'h20000, 32'h20000);
		rchk(aout_pkg::OFS_SIZE, 32'hffffffff, 32'h2);
		far.got_q.delete();
		wr(aout_pkg::OFS_OPS, 32'h123);
		play(4);
		nchk(4);
		for (int i = 0; i < 4; i++)
			dchk(i, (i % 2 == 1) ? 17'h10500 : 17'h00400);
		rchk(aout_pkg::OFS_SIZE, 32'hffffffff, 32'h2);
		rchk(aout_pkg::OFS_OPS, 32'h20000, 32'h0);
		// bursts: each trigger plays one frame and stops at the marker
		far.got_q.delete();
		wr(aout_pkg::OFS_OPS, 32'h180123);
		play(4);
		nchk(2);
		rchk(aout_pkg::OFS_OPS, 32'h40000, 32'h40000);
		far.trig();
		play(4);
		nchk(4);
		dchk(2, 17'h00400);
		dchk(3, 17'h10500);
		// correction: half gain plus offset, seen at the converter side
		wr(aout_pkg::OFS_OPS, 32'h803);
		wr(aout_pkg::OFS_CORR, 32'h00104000);
		wr(aout_pkg::OFS_SAMPLE, 32'h00010100);
		wr(aout_pkg::OFS_OPS, 32'h23);
		play(1);
		nchk(5);
		dchk(4, 17'h10090);
		end_sim();
	end
endmodule : aout_buffer_test
`default_nettype wire
